// ### include/servo_param_consts.svh
// Purpose: constants for the servo parameter, torque and status logic
// Assumes: 25 MHz clk_sys, 16-bit parameter words, 8-bit word address
// Notes: parameter slots sit at base + slot index
//
// Overview of operation
// - writing one to alarm clear drops alarm
// - encoder type accepts only 4 or 5
// - inertia ratio 1 to 500, default 100
// - torque mode: select bits pick torque one-four
// - match frames at station address 1-254
// - baud tick rate is setting times 100
// - format code sets parity and stop bits
// - comm error alarms and stops if enabled
// - zero speed flag while speed below threshold
// - agreement flag while speed error below band
// - second and third gear numerators, 0-32767
`ifndef SERVO_PARAM_CONSTS_SVH
`define SERVO_PARAM_CONSTS_SVH

`define CLK_HZ 26'd25000000
`define BAUD_MULT 17'd100

`define ADDR_BASE 8'h3d
`define SLOT_COUNT 18
`define SLOT_ALARM_CLEAR 0
`define SLOT_ENCODER 1
`define SLOT_INERTIA 2
`define SLOT_TORQUE_ONE 3
`define SLOT_STATION 10
`define SLOT_BAUD 11
`define SLOT_FORMAT 12
`define SLOT_ERR_ACTION 13
`define SLOT_ZERO_SPEED 14
`define SLOT_AGREE_BAND 15
`define SLOT_GEAR_SECOND 16
`define SLOT_GEAR_THIRD 17

`define ADDR_CONTROL 8'h50
`define ADDR_STATUS 8'h51
`define ADDR_IRQ_STATUS 8'h52
`define ADDR_IRQ_MASK 8'h53

`define RST_ZERO 16'h0000
`define RST_INERTIA 16'h0064
`define RST_STATION 16'h0001
`define RST_BAUD 16'h0060
`define RST_ERR_ACTION 16'h0001
`define RST_ZERO_SPEED 16'h000a
`define RST_AGREE_BAND 16'h000a
`define RST_ENCODER 16'h0005

`define ENC_SINGLE 17'sh00004
`define ENC_MULTI 17'sh00005
`define LIM_INERTIA_LO 17'sh00001
`define LIM_INERTIA_HI 17'sh001f4
`define LIM_TORQUE_LO (-17'sh0012c)
`define LIM_TORQUE_HI 17'sh0012c
`define LIM_STATION_LO 17'sh00001
`define LIM_STATION_HI 17'sh000fe
`define LIM_BAUD_LO 17'sh00030
`define LIM_BAUD_HI 17'sh00480
`define LIM_FORMAT_HI 17'sh00003
`define LIM_ACTION_HI 17'sh00001
`define LIM_SPEED_HI 17'sh003e8
`define LIM_GEAR_HI 17'sh07fff
`define LIM_ZERO 17'sh00000

`define ALARM_CLEAR_GO 16'h0001
`define ACTION_ALARM 16'h0001
`define MODE_TORQUE 2'h2
`define FMT_N2 2'h0
`define FMT_E1 2'h1
`define FMT_O1 2'h2

`define IRQ_COMM_ERR 0
`define IRQ_ALARM 1
`define IRQ_ZERO_SPEED 2
`define IRQ_AGREE 3
`define IRQ_WIDTH 4

`endif

// ### include/servo_param_pkg.sv
// Purpose: shared types for the servo parameter logic
// Assumes: speeds are signed r/min, 16 bits
// Notes: constants live in servo_param_consts.svh
package servo_param_pkg;
  typedef struct packed {
    logic signed [15:0] motor_speed;
    logic signed [15:0] speed_cmd;
  } speed_sample_t;

  typedef struct packed {
    logic parity;
    logic framing;
    logic checksum;
  } comm_err_t;

  typedef struct packed {
    logic parity_en;
    logic parity_odd;
    logic two_stop;
  } frame_fmt_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ALARM = 2'b01
  } run_state_t;
endpackage : servo_param_pkg

// ### rtl/speed_compare.sv
// Purpose: zero speed, agreement and clamp comparisons
// Assumes: inputs from logic on the same clock
// Notes: purely combinational, the top registers the results
`timescale 1ns/10ps
`default_nettype none
module speed_compare (
  input wire servo_param_pkg::speed_sample_t sample,
  input wire logic [15:0] zero_thr,
  input wire logic [15:0] agree_band,
  input wire logic clamp_on,
  output logic zero_speed,
  output logic agree,
  output logic signed [15:0] cmd_out
);
  import servo_param_pkg::*;

  logic signed [17:0] diff;
  logic [17:0] diff_abs;
  logic [16:0] spd_abs;
  logic [16:0] cmd_abs;

  // widen first so full-scale speeds cannot overflow
  always_comb begin
    diff = 18'(sample.motor_speed) - 18'(sample.speed_cmd);
    diff_abs = diff[17] ? 18'(-diff) : 18'(diff);
    spd_abs = sample.motor_speed[15] ? 17'(-17'(sample.motor_speed)) : 17'(sample.motor_speed);
    cmd_abs = sample.speed_cmd[15] ? 17'(-17'(sample.speed_cmd)) : 17'(sample.speed_cmd);
  end

  assign zero_speed = spd_abs < 17'(zero_thr);
  assign agree = diff_abs < 18'(agree_band);
  assign cmd_out = (clamp_on && (cmd_abs < 17'(zero_thr))) ? 16'sh0000 : sample.speed_cmd;
endmodule : speed_compare
`default_nettype wire

// ### rtl/servo_param_torque_status_logic.sv
// Purpose: parameter registers, torque select, speed status, link setup
// Assumes: comm fault pulses and speeds come from logic on clk_sys
// Notes: select and clamp inputs are pins and are synchronised
`timescale 1ns/10ps
`default_nettype none
`include "servo_param_consts.svh"
module servo_param_torque_status_logic #(
  parameter logic [15:0] ENCODER_DEFAULT = `RST_ENCODER
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic torque_select_bit0,
  input wire logic torque_select_bit1,
  input wire logic zero_clamp_input,
  input wire servo_param_pkg::speed_sample_t speed_in,
  input wire servo_param_pkg::comm_err_t comm_err,
  input wire logic frame_addr_valid,
  input wire logic [7:0] frame_addr,
  output logic signed [15:0] torque_cmd,
  output logic signed [15:0] speed_cmd_out,
  output logic zero_speed_flag,
  output logic speed_agreement_flag,
  output logic addr_match,
  output logic baud_tick,
  output servo_param_pkg::frame_fmt_t frame_fmt,
  output logic drive_enable,
  output logic alarm_active,
  output logic irq
);
  import servo_param_pkg::*;

  // per-slot reset value
  function automatic logic [15:0] rst_of(input int s);
    case (s)
      `SLOT_ENCODER: rst_of = ENCODER_DEFAULT;
      `SLOT_INERTIA: rst_of = `RST_INERTIA;
      `SLOT_STATION: rst_of = `RST_STATION;
      `SLOT_BAUD: rst_of = `RST_BAUD;
      `SLOT_ERR_ACTION: rst_of = `RST_ERR_ACTION;
      `SLOT_ZERO_SPEED: rst_of = `RST_ZERO_SPEED;
      `SLOT_AGREE_BAND: rst_of = `RST_AGREE_BAND;
      default: rst_of = `RST_ZERO;
    endcase
  endfunction : rst_of

  // out-of-range writes are dropped so the old value stays
  function automatic logic value_ok(input int s, input logic [15:0] v);
    logic signed [16:0] sv;
    logic signed [16:0] uv;
    sv = 17'($signed(v));
    uv = $signed({1'b0, v});
    case (s)
      `SLOT_ENCODER: value_ok = (uv == `ENC_SINGLE) || (uv == `ENC_MULTI);
      `SLOT_INERTIA: value_ok = (uv >= `LIM_INERTIA_LO) && (uv <= `LIM_INERTIA_HI);
      `SLOT_TORQUE_ONE, `SLOT_TORQUE_ONE + 1, `SLOT_TORQUE_ONE + 2, `SLOT_TORQUE_ONE + 3:
        value_ok = (sv >= `LIM_TORQUE_LO) && (sv <= `LIM_TORQUE_HI);
      `SLOT_STATION: value_ok = (uv >= `LIM_STATION_LO) && (uv <= `LIM_STATION_HI);
      `SLOT_BAUD: value_ok = (uv >= `LIM_BAUD_LO) && (uv <= `LIM_BAUD_HI);
      `SLOT_FORMAT: value_ok = uv <= `LIM_FORMAT_HI;
      `SLOT_ERR_ACTION: value_ok = uv <= `LIM_ACTION_HI;
      `SLOT_ZERO_SPEED, `SLOT_AGREE_BAND: value_ok = uv <= `LIM_SPEED_HI;
      `SLOT_GEAR_SECOND, `SLOT_GEAR_THIRD: value_ok = uv <= `LIM_GEAR_HI;
      default: value_ok = 1'b0;
    endcase
  endfunction : value_ok

  logic [15:0] slot_q [`SLOT_COUNT];
  logic [7:0] slot_idx;
  logic in_slots;
  logic [1:0] control_mode_param_q;
  logic [`IRQ_WIDTH-1:0] irq_status_q;
  logic [`IRQ_WIDTH-1:0] irq_mask_q;
  logic [`IRQ_WIDTH-1:0] irq_event;
  logic [1:0] sel_meta_q;
  logic [1:0] sel_q;
  logic clamp_meta_q;
  logic clamp_q;
  run_state_t state_q;
  logic comm_fault;
  logic alarm_clear_req;
  logic alarm_raise;
  logic zs_now;
  logic agree_now;
  logic signed [15:0] cmd_now;
  logic [24:0] baud_acc_q;
  logic [25:0] baud_sum;
  logic [16:0] baud_rate;

  assign slot_idx = reg_addr - `ADDR_BASE;
  assign in_slots = (reg_addr >= `ADDR_BASE) && (slot_idx < 8'(`SLOT_COUNT));

  // parameter slots, one register per entry except the alarm clear slot
  for (genvar i = 0; i < `SLOT_COUNT; i++) begin : g_slot
    if (i == `SLOT_ALARM_CLEAR) begin : g_pulse
      // self-clearing: a stored one would re-clear forever
      assign slot_q[i] = `RST_ZERO;
    end else begin : g_store
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          slot_q[i] <= rst_of(i);
        end else if (reg_wr && in_slots && (slot_idx == 8'(i)) && value_ok(i, reg_wdata)) begin
          slot_q[i] <= reg_wdata;
        end
      end
    end
  end

  assign alarm_clear_req = reg_wr && in_slots && (slot_idx == 8'(`SLOT_ALARM_CLEAR))
                           && (reg_wdata == `ALARM_CLEAR_GO);

  // own control register: control mode
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      control_mode_param_q <= 2'h0;
    end else if (reg_wr && (reg_addr == `ADDR_CONTROL)) begin
      control_mode_param_q <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_mask_q <= '0;
    end else if (reg_wr && (reg_addr == `ADDR_IRQ_MASK)) begin
      irq_mask_q <= reg_wdata[`IRQ_WIDTH-1:0];
    end
  end

  // set wins over the write-one clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_status_q <= '0;
    end else if (reg_wr && (reg_addr == `ADDR_IRQ_STATUS)) begin
      irq_status_q <= (irq_status_q & ~reg_wdata[`IRQ_WIDTH-1:0]) | irq_event;
    end else begin
      irq_status_q <= irq_status_q | irq_event;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_status_q | irq_event) & irq_mask_q);
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (in_slots) begin
      reg_rdata <= slot_q[slot_idx[4:0]];
    end else begin
      case (reg_addr)
        `ADDR_CONTROL: reg_rdata <= {14'h0000, control_mode_param_q};
        `ADDR_STATUS: reg_rdata <= {12'h000, clamp_q, zero_speed_flag, speed_agreement_flag,
                                    state_q == ST_ALARM};
        `ADDR_IRQ_STATUS: reg_rdata <= {12'h000, irq_status_q};
        `ADDR_IRQ_MASK: reg_rdata <= {12'h000, irq_mask_q};
        default: reg_rdata <= '0;
      endcase
    end
  end

  // pin synchronisers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sel_meta_q <= 2'h0;
      sel_q <= 2'h0;
      clamp_meta_q <= 1'b0;
      clamp_q <= 1'b0;
    end else begin
      sel_meta_q <= {torque_select_bit1, torque_select_bit0};
      sel_q <= sel_meta_q;
      clamp_meta_q <= zero_clamp_input;
      clamp_q <= clamp_meta_q;
    end
  end

  // torque command: two-bit index into internal torque one-four
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      torque_cmd <= 16'sh0000;
    end else if (control_mode_param_q == `MODE_TORQUE) begin
      torque_cmd <= $signed(slot_q[`SLOT_TORQUE_ONE + int'(sel_q)]);
    end else begin
      torque_cmd <= 16'sh0000;
    end
  end

  speed_compare u_cmp (
    .sample(speed_in),
    .zero_thr(slot_q[`SLOT_ZERO_SPEED]),
    .agree_band(slot_q[`SLOT_AGREE_BAND]),
    .clamp_on(clamp_q),
    .zero_speed(zs_now),
    .agree(agree_now),
    .cmd_out(cmd_now)
  );

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      zero_speed_flag <= 1'b0;
      speed_agreement_flag <= 1'b0;
      speed_cmd_out <= 16'sh0000;
    end else begin
      zero_speed_flag <= zs_now;
      speed_agreement_flag <= agree_now;
      speed_cmd_out <= cmd_now;
    end
  end

  // comm fault handling
  assign comm_fault = comm_err.parity | comm_err.framing | comm_err.checksum;
  assign alarm_raise = comm_fault && (slot_q[`SLOT_ERR_ACTION] == `ACTION_ALARM);

  // a fault in the clear cycle keeps the alarm
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: if (alarm_raise) state_q <= ST_ALARM;
        ST_ALARM: if (alarm_clear_req && !alarm_raise) state_q <= ST_RUN;
        default: state_q <= ST_ALARM;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      drive_enable <= 1'b0;
      alarm_active <= 1'b0;
    end else begin
      drive_enable <= (state_q == ST_RUN) && !alarm_raise;
      alarm_active <= (state_q == ST_ALARM) || alarm_raise;
    end
  end

  assign irq_event = {agree_now & ~speed_agreement_flag, zs_now & ~zero_speed_flag,
                      alarm_raise & (state_q == ST_RUN), comm_fault};

  // station match
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      addr_match <= 1'b0;
    end else begin
      addr_match <= frame_addr_valid && (16'(frame_addr) == slot_q[`SLOT_STATION]);
    end
  end

  // fractional divider: no divide, rate error stays below one cycle
  assign baud_rate = 17'(slot_q[`SLOT_BAUD] * `BAUD_MULT);
  assign baud_sum = 26'(baud_acc_q) + 26'(baud_rate);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      baud_acc_q <= '0;
      baud_tick <= 1'b0;
    end else if (baud_sum >= `CLK_HZ) begin
      baud_acc_q <= 25'(baud_sum - `CLK_HZ);
      baud_tick <= 1'b1;
    end else begin
      baud_acc_q <= baud_sum[24:0];
      baud_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      frame_fmt <= '{parity_en: 1'b0, parity_odd: 1'b0, two_stop: 1'b1};
    end else begin
      frame_fmt.parity_en <= (slot_q[`SLOT_FORMAT][1:0] == `FMT_E1)
                             || (slot_q[`SLOT_FORMAT][1:0] == `FMT_O1);
      frame_fmt.parity_odd <= slot_q[`SLOT_FORMAT][1:0] == `FMT_O1;
      frame_fmt.two_stop <= slot_q[`SLOT_FORMAT][1:0] == `FMT_N2;
    end
  end

  // checks
  chk_alarm_clear_drop: assert property (@(posedge clk_sys) disable iff (reset)
    (state_q == ST_ALARM && alarm_clear_req && !alarm_raise) |=> state_q == ST_RUN)
    else $error("alarm not cleared");
  chk_encoder_legal: assert property (@(posedge clk_sys) disable iff (reset)
    reg_wr && in_slots && slot_idx == 8'(`SLOT_ENCODER) && reg_wdata == 16'h0003
    |=> $stable(slot_q[`SLOT_ENCODER]))
    else $error("illegal encoder type taken");
  chk_inertia_range: assert property (@(posedge clk_sys) disable iff (reset)
    slot_q[`SLOT_INERTIA] >= 16'h0001 && slot_q[`SLOT_INERTIA] <= 16'h01f4)
    else $error("inertia ratio out of range");
  chk_torque_pick: assert property (@(posedge clk_sys) disable iff (reset)
    control_mode_param_q == `MODE_TORQUE && sel_q == 2'h3
    |=> torque_cmd == $signed($past(slot_q[`SLOT_TORQUE_ONE + 3])))
    else $error("torque four not selected");
  chk_station_match: assert property (@(posedge clk_sys) disable iff (reset)
    addr_match |-> $past(frame_addr_valid) && 16'($past(frame_addr)) == $past(slot_q[`SLOT_STATION]))
    else $error("false station match");
  chk_format_stop: assert property (@(posedge clk_sys) disable iff (reset)
    slot_q[`SLOT_FORMAT][1:0] == 2'h3 [*2] |-> !frame_fmt.two_stop && !frame_fmt.parity_en)
    else $error("format three wrong");
  chk_fault_stops: assert property (@(posedge clk_sys) disable iff (reset)
    alarm_raise |=> !drive_enable [*2])
    else $error("drive kept running after fault");
  chk_fault_ignored: assert property (@(posedge clk_sys) disable iff (reset)
    comm_fault && slot_q[`SLOT_ERR_ACTION] == 16'h0000 && state_q == ST_RUN |=> state_q == ST_RUN)
    else $error("alarm raised with continue selected");
  chk_zero_speed: assert property (@(posedge clk_sys) disable iff (reset)
    speed_in.motor_speed == 16'sh0000 && slot_q[`SLOT_ZERO_SPEED] != 16'h0000 |=> zero_speed_flag)
    else $error("zero speed flag missing");
  chk_clamp_zero: assert property (@(posedge clk_sys) disable iff (reset)
    clamp_q && !speed_in.speed_cmd[15] && 16'(speed_in.speed_cmd) < slot_q[`SLOT_ZERO_SPEED]
    |=> speed_cmd_out == 16'sh0000)
    else $error("clamped command not zero");
  chk_agree_flag: assert property (@(posedge clk_sys) disable iff (reset)
    speed_in.motor_speed == speed_in.speed_cmd && slot_q[`SLOT_AGREE_BAND] != 16'h0000
    |=> speed_agreement_flag)
    else $error("agreement flag missing");
  chk_gear_range: assert property (@(posedge clk_sys) disable iff (reset)
    !slot_q[`SLOT_GEAR_SECOND][15] && !slot_q[`SLOT_GEAR_THIRD][15])
    else $error("gear numerator out of range");
  chk_fault_sticky: assert property (@(posedge clk_sys) disable iff (reset)
    comm_err.framing |=> irq_status_q[`IRQ_COMM_ERR])
    else $error("framing fault not flagged");

  cov_torque_mode: cover property (@(posedge clk_sys) disable iff (reset)
    control_mode_param_q == `MODE_TORQUE && sel_q == 2'h2);
  cov_alarm_cycle: cover property (@(posedge clk_sys) disable iff (reset)
    state_q == ST_ALARM ##[1:50] state_q == ST_RUN);
  cov_clamp_hit: cover property (@(posedge clk_sys) disable iff (reset)
    clamp_q && speed_in.speed_cmd != 16'sh0000 ##1 speed_cmd_out == 16'sh0000);
  cov_irq_raise: cover property (@(posedge clk_sys) disable iff (reset) $rose(irq));
endmodule : servo_param_torque_status_logic
`default_nettype wire

// ### rtl/_unused_placeholder_none.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ### testbench/fieldbus_master_model.sv
// Purpose: far side of the link, frames and line faults toward the block
// Assumes: decoded frames arrive on clk_sys, one strobe per frame
// Notes: address line shows the inverse of the last value while idle
`timescale 1ns/10ps
`default_nettype none
module fieldbus_master_model (
  input wire logic clk_sys,
  output servo_param_pkg::comm_err_t comm_err,
  output logic frame_addr_valid,
  output logic [7:0] frame_addr
);
  import servo_param_pkg::*;
  initial begin
    comm_err = '0;
    frame_addr_valid = 1'b0;
    frame_addr = 8'h00;
  end
  // one frame addressed to a station, valid for one cycle
  task automatic send_frame(input logic [7:0] a);
    @(posedge clk_sys);
    frame_addr_valid <= 1'b1;
    frame_addr <= a;
    @(posedge clk_sys);
    frame_addr_valid <= 1'b0;
    frame_addr <= ~a;
  endtask : send_frame
  // a bad frame: parity, framing or checksum fault, one cycle
  task automatic send_fault(input logic [2:0] kind);
    @(posedge clk_sys);
    comm_err <= kind;
    @(posedge clk_sys);
    comm_err <= '0;
  endtask : send_fault
endmodule : fieldbus_master_model
`default_nettype wire

// ### testbench/tb.sv
// Purpose: register, torque, speed status and link checks of the block
// Assumes: read data one cycle after the read strobe, zero otherwise
// Notes: pin inputs pass two sync flops, so waits allow for them
`timescale 1ns/10ps
`default_nettype none
`include "servo_param_consts.svh"
module tb;
  import servo_param_pkg::*;
  logic clk_sys, reset, reg_wr, reg_rd, sel0, sel1, clamp;
  logic [7:0] reg_addr, frame_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  speed_sample_t speed_in;
  comm_err_t comm_err;
  frame_fmt_t frame_fmt;
  logic frame_addr_valid, addr_match, baud_tick, drive_enable, alarm_active, irq;
  logic zero_speed_flag, speed_agreement_flag;
  logic signed [15:0] torque_cmd, speed_cmd_out;
  int err_total = 0;
  int n_checks = 0;
  int cnt;
  // reset table: address, expected value
  logic [23:0] rst_tab [0:16] = '{24'h3d0000, 24'h3e0005, 24'h3f0064, 24'h400000, 24'h410000, 24'h420000,
    24'h430000, 24'h470001, 24'h480060, 24'h490000, 24'h4a0001, 24'h4b000a, 24'h4c000a, 24'h4d0000,
    24'h4e0000, 24'h500000, 24'h530000};
  // write table: address, data, value read back (bad values leave the old one)
  logic [39:0] wr_tab [0:22] = '{40'h3e_0003_0005, 40'h3e_0004_0004, 40'h3f_0000_0064, 40'h3f_01f4_01f4,
    40'h3f_01f5_01f4, 40'h40_012d_0000, 40'h40_fed3_0000, 40'h40_fed4_fed4, 40'h47_00ff_0001,
    40'h47_00fe_00fe, 40'h47_0000_00fe, 40'h48_002f_0060, 40'h48_0480_0480, 40'h49_0004_0000,
    40'h4a_0002_0001, 40'h4b_03e9_000a, 40'h4c_03e9_000a, 40'h4d_7fff_7fff, 40'h4d_8000_7fff,
    40'h4e_7fff_7fff, 40'h3d_0001_0000, 40'h44_1234_0000, 40'h51_00ff_0006};
  logic [15:0] tq [0:3] = '{16'hfed4, 16'h012c, 16'h0005, 16'hffff};
  logic [2:0] fmt_x [0:3] = '{3'b001, 3'b100, 3'b110, 3'b000};
  // speed table: motor, cmd, clamp, zero flag, agree flag, cmd out
  logic [50:0] sp_tab [0:6] = '{{16'd9, 16'd9, 3'b011, 16'd9}, {16'd10, 16'd20, 3'b000, 16'd20},
    {-16'sd9, 16'd0, 3'b011, 16'd0}, {16'd100, 16'd91, 3'b101, 16'd91}, {16'd100, 16'd9, 3'b100, 16'd0},
    {16'd0, -16'sd9, 3'b111, 16'd0}, {16'd0, 16'd10, 3'b110, 16'd10}};

  servo_param_torque_status_logic i_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .torque_select_bit0(sel0), .torque_select_bit1(sel1), .zero_clamp_input(clamp), .speed_in(speed_in),
    .comm_err(comm_err), .frame_addr_valid(frame_addr_valid), .frame_addr(frame_addr),
    .torque_cmd(torque_cmd), .speed_cmd_out(speed_cmd_out), .zero_speed_flag(zero_speed_flag),
    .speed_agreement_flag(speed_agreement_flag), .addr_match(addr_match), .baud_tick(baud_tick),
    .frame_fmt(frame_fmt), .drive_enable(drive_enable), .alarm_active(alarm_active), .irq(irq));
  fieldbus_master_model i_master (.clk_sys(clk_sys), .comm_err(comm_err),
    .frame_addr_valid(frame_addr_valid), .frame_addr(frame_addr));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_checks++;
    if (got !== ex) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  // watchdog: a hung run still reaches the verdict
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    close_out();
  end

  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, sel0, sel1, clamp} = '0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    speed_in = '0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rst_tab[i]) begin
      rd(rst_tab[i][23:16], v);
      chk("reset value", rst_tab[i][15:0], v);
    end
    $display("test reset values done");
    foreach (wr_tab[i]) begin
      wr(wr_tab[i][39:32], wr_tab[i][31:16]);
      rd(wr_tab[i][39:32], v);
      chk("write range", wr_tab[i][15:0], v);
    end
    $display("test ranges done");
    for (int s = 1; s < 4; s++) wr(8'h40 + 8'(s), tq[s]);
    wr(`ADDR_CONTROL, 16'h0002);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      {sel1, sel0} <= 2'(s);
      idle(5);
      chk("torque_cmd", tq[s], torque_cmd);
    end
    wr(`ADDR_CONTROL, 16'h0000);
    idle(2);
    chk("torque_cmd off", 16'h0000, torque_cmd);
    $display("test torque select done");
    foreach (sp_tab[i]) begin
      @(posedge clk_sys);
      speed_in <= {sp_tab[i][50:35], sp_tab[i][34:19]};
      clamp <= sp_tab[i][18];
      idle(5);
      chk("zero_speed_flag", {15'h0, sp_tab[i][17]}, {15'h0, zero_speed_flag});
      chk("speed_agreement_flag", {15'h0, sp_tab[i][16]}, {15'h0, speed_agreement_flag});
      chk("speed_cmd_out", sp_tab[i][15:0], speed_cmd_out);
    end
    $display("test speed status done");
    i_master.send_frame(8'hfe);
    #1 chk("addr_match hit", 16'h0001, {15'h0, addr_match});
    i_master.send_frame(8'h01);
    #1 chk("addr_match miss", 16'h0000, {15'h0, addr_match});
    $display("test station done");
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_BASE + 8'h0c, 16'(c));
      idle(2);
      chk("frame_fmt", {13'h0, fmt_x[c]}, {13'h0, frame_fmt});
    end
    $display("test frame format done");
    cnt = 0;
    repeat (2170) begin
      @(posedge clk_sys);
      #1 if (baud_tick === 1'b1) cnt++;
    end
    chk("baud ticks near 10", 16'h0001, {15'h0, cnt >= 9 && cnt <= 11});
    $display("test baud done");
    wr(`ADDR_IRQ_MASK, 16'h0003);
    for (int k = 0; k < 3; k++) begin
      wr(`ADDR_IRQ_STATUS, 16'h000f);
      i_master.send_fault(3'b001 << k);
      #1 chk("alarm_active", 16'h0001, {15'h0, alarm_active});
      chk("drive_enable", 16'h0000, {15'h0, drive_enable});
      idle(1);
      chk("irq", 16'h0001, {15'h0, irq});
      rd(`ADDR_IRQ_STATUS, v);
      chk("irq status", 16'h0003, v & 16'h0003);
      wr(`ADDR_IRQ_STATUS, 16'h0003);
      idle(2);
      chk("irq cleared", 16'h0000, {15'h0, irq});
      wr(`ADDR_BASE, 16'h0001);
      idle(3);
      chk("alarm cleared", 16'h0000, {15'h0, alarm_active});
      chk("drive restored", 16'h0001, {15'h0, drive_enable});
    end
    wr(`ADDR_BASE + 8'h0d, 16'h0000);
    i_master.send_fault(3'b010);
    idle(2);
    chk("no alarm", 16'h0000, {15'h0, alarm_active});
    chk("drive kept", 16'h0001, {15'h0, drive_enable});
    rd(`ADDR_IRQ_STATUS, v);
    chk("fault noted", 16'h0001, v & 16'h0003);
    $display("test comm errors done");
    close_out();
  end
endmodule : tb
`default_nettype wire
